// file: hw/bcc_core.sv
`timescale 1ns/10ps
`default_nettype none
module bcc_core
  import bcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic osc_tick,
  input wire logic osc_fail_event,
  input wire logic power_down,
  input wire logic bus_ptr_load,
  input wire logic [2:0] bus_ptr_val,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wr_data,
  input wire logic bus_ack_clk,
  input wire logic bus_read,
  input wire logic bus_stop,
  output logic [7:0] rd_data,
  output logic [2:0] ptr,
  output logic freq_or_level_pin_o,
  output logic freq_or_level_pin_oe
);

  // ==========================================================
  // Register image
  function automatic logic [7:0] reg_byte(input logic [2:0] a, input bcc_time_t t,
                                          input bcc_ctrl_t c);
    case (a)
      ADDR_SEC: return {c.osc_halt, t.sec[6:0]};
      ADDR_MIN: return {c.osc_fault_flag, t.min[6:0]};
      ADDR_HOUR: return {c.century_toggle_enable, t.cb, t.hour[5:0]};
      ADDR_DOW: return t.dow & MASK_DOW;
      ADDR_DATE: return t.date & MASK_DATE;
      ADDR_MONTH: return t.month & MASK_MONTH;
      ADDR_YEAR: return t.year & MASK_YEAR;
      default: return {c.out_level, c.freq_probe_enable, c.trim_dir, c.trim_mag};
    endcase
  endfunction

  // ==========================================================
  // State
  bcc_state_t s;
  bcc_state_t n;
  bcc_time_t stepped;
  logic min_roll;
  logic run_tick;
  logic cal_now;
  logic [15:0] term;
  logic pin_level;

  bcc_time_step u_step (
    .now_t(s.t_int),
    .cent_en(s.ctrl.century_toggle_enable),
    .next_t(stepped),
    .min_roll(min_roll)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    n = s;
    run_tick = osc_tick && !s.ctrl.osc_halt;
    // One corrected second per affected minute, chosen as second 00
    cal_now = (s.t_int.sec == 8'h00) && (s.cal_min < {s.ctrl.trim_mag, 1'b0});
    if (!cal_now) begin
      term = TERM_NORM;
    end else if (s.ctrl.trim_dir) begin
      term = TERM_FAST;
    end else begin
      term = TERM_SLOW;
    end
    if (run_tick) begin
      n.raw = s.raw + 6'h01;
      if (s.div >= term) begin
        n.div = 16'h0000;
        n.t_int = stepped;
        if (min_roll) begin
          n.cal_min = s.cal_min + 6'h01;
        end
      end else begin
        n.div = s.div + 16'h0001;
      end
    end

    // Pointer moves on load or acknowledge only
    if (bus_ptr_load) begin
      n.ptr = bus_ptr_val;
    end else if (bus_ack_clk) begin
      n.ptr = s.ptr + 3'h1;
    end

    // Freeze stays until stop or pointer parks on the trim address
    if (bus_stop || n.ptr == ADDR_TRIM) begin
      n.freeze = 1'b0;
    end else if (bus_read) begin
      n.freeze = 1'b1;
    end

    if (!n.freeze) begin
      n.t_usr = n.t_int;
    end

    // Writes land in both copies so the user sees them at once
    if (bus_wr) begin
      if (s.ptr != ADDR_TRIM) begin
        n.div = 16'h0000;
      end
      case (s.ptr)
        ADDR_SEC: begin
          n.t_int.sec = bus_wr_data & MASK_SEC;
          n.ctrl.osc_halt = bus_wr_data[BIT_HALT];
        end
        ADDR_MIN: begin
          n.t_int.min = bus_wr_data & MASK_MIN;
          if (!bus_wr_data[BIT_FAULT]) begin
            n.ctrl.osc_fault_flag = 1'b0;
          end
        end
        ADDR_HOUR: begin
          n.t_int.hour = bus_wr_data & MASK_HOUR;
          n.t_int.cb = bus_wr_data[BIT_CENT];
          n.ctrl.century_toggle_enable = bus_wr_data[BIT_CENT_EN];
        end
        ADDR_DOW: n.t_int.dow = bus_wr_data & MASK_DOW;
        ADDR_DATE: n.t_int.date = bus_wr_data & MASK_DATE;
        ADDR_MONTH: n.t_int.month = bus_wr_data & MASK_MONTH;
        ADDR_YEAR: n.t_int.year = bus_wr_data & MASK_YEAR;
        default: begin
          n.ctrl.out_level = bus_wr_data[BIT_OUT];
          n.ctrl.freq_probe_enable = bus_wr_data[BIT_PROBE];
          n.ctrl.trim_dir = bus_wr_data[BIT_DIR];
          n.ctrl.trim_mag = bus_wr_data[4:0] & MASK_MAG[4:0];
        end
      endcase
      n.t_usr = n.t_int;
    end

    // Sources of the fault flag win over a clear in the same cycle
    if (n.ctrl.osc_halt || osc_fail_event) begin
      n.ctrl.osc_fault_flag = 1'b1;
    end
    if (power_down) begin
      n.ctrl.freq_probe_enable = 1'b0;
    end

    n.rd_data = reg_byte(n.ptr, n.t_usr, n.ctrl);

    // Probe taken from a free raw counter, so trim never moves it
    if (n.ctrl.freq_probe_enable) begin
      pin_level = n.ctrl.osc_halt ? 1'b1 : n.raw[PROBE_BIT];
    end else begin
      pin_level = n.ctrl.out_level;
    end
    n.pin_oe = !pin_level;
    n.pin_o = 1'b0;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '{TIME_RST, TIME_RST, CTRL_RST, 16'h0000, 6'h00, 6'h00, 3'h0, 1'b0,
             8'h00, 1'b0, 1'b0};
    end else if (clk_en) begin
      s <= n;
    end
  end

  assign rd_data = s.rd_data;
  assign ptr = s.ptr;
  assign freq_or_level_pin_o = s.pin_o;
  assign freq_or_level_pin_oe = s.pin_oe;

  // ==========================================================
  // Assertions
  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_halt_no_count: assert property (clk_en && s.ctrl.osc_halt && !bus_wr |=>
    $stable(s.div) && $stable(s.t_int))
    else $error("time advanced while halted");

  a_fault_on_halt: assert property (clk_en && s.ctrl.osc_halt |=> s.ctrl.osc_fault_flag)
    else $error("fault flag not set while halted");

  a_fault_sticky: assert property (clk_en && s.ctrl.osc_fault_flag &&
    !(bus_wr && s.ptr == ADDR_MIN && !bus_wr_data[BIT_FAULT]) |=> s.ctrl.osc_fault_flag)
    else $error("fault flag cleared without write");

  a_ptr_advance: assert property (clk_en && bus_ack_clk && !bus_ptr_load |=>
    s.ptr == $past(s.ptr) + 3'h1)
    else $error("pointer did not advance on ack");

  a_ptr_hold: assert property (clk_en && !bus_ack_clk && !bus_ptr_load |=> $stable(s.ptr))
    else $error("pointer moved without ack");

  a_freeze_hold: assert property (clk_en && s.freeze && !bus_stop && !bus_wr &&
    s.ptr != ADDR_TRIM && !bus_ack_clk && !bus_ptr_load |=> $stable(s.t_usr))
    else $error("user copy changed while frozen");

  a_div_reset: assert property (clk_en && bus_wr && s.ptr != ADDR_TRIM |=> s.div == 16'h0000)
    else $error("divider not reset by clock write");

  a_dow_zero_bits: assert property (s.ptr == ADDR_DOW && !bus_wr && !bus_ack_clk &&
    !bus_ptr_load |=> !clk_en || s.rd_data[7:3] == 5'h00)
    else $error("weekday upper bits not zero");

  a_probe_halted: assert property (clk_en && n.ctrl.freq_probe_enable &&
    n.ctrl.osc_halt |=> !s.pin_oe)
    else $error("probe pin pulled low while halted");

  a_probe_clear: assert property (clk_en && power_down |=> !s.ctrl.freq_probe_enable)
    else $error("probe enable kept through power-down");

  a_pin_open_drain: assert property (s.pin_o == 1'b0)
    else $error("pin driven high");

  a_cent_hold: assert property (clk_en && !s.ctrl.century_toggle_enable && !bus_wr |=>
    $stable(s.t_int.cb))
    else $error("century flag moved while disabled");

  a_pin_level: assert property (clk_en && !n.ctrl.freq_probe_enable |=>
    s.pin_oe == !$past(n.ctrl.out_level))
    else $error("pin does not follow level bit");

  a_sec_bcd: assert property (s.t_int.sec[3:0] <= 4'h9 && s.t_int.sec[7:4] <= 4'h5)
    else $error("seconds not valid BCD");

  a_cal_span: assert property (clk_en && run_tick && s.div == TERM_NORM &&
    s.t_int.sec != 8'h00 |=> s.div == 16'h0000)
    else $error("uncorrected second has wrong length");

  c_minute_roll: cover property (clk_en && run_tick && min_roll && s.div >= term);
  c_frozen_read: cover property (s.freeze && bus_ack_clk ##1 !s.freeze);
  c_fast_trim: cover property (cal_now && s.ctrl.trim_dir && run_tick);
  c_probe_on: cover property (s.ctrl.freq_probe_enable && !s.pin_oe ##1 s.pin_oe);

endmodule // bcc_core
`default_nettype wire

// file: hw/bcc_pkg.sv
package bcc_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [2:0] ADDR_SEC = 3'h0;
  localparam logic [2:0] ADDR_MIN = 3'h1;
  localparam logic [2:0] ADDR_HOUR = 3'h2;
  localparam logic [2:0] ADDR_DOW = 3'h3;
  localparam logic [2:0] ADDR_DATE = 3'h4;
  localparam logic [2:0] ADDR_MONTH = 3'h5;
  localparam logic [2:0] ADDR_YEAR = 3'h6;
  localparam logic [2:0] ADDR_TRIM = 3'h7;

  // ==========================================================
  // Field positions and masks
  localparam int BIT_HALT = 7;
  localparam int BIT_FAULT = 7;
  localparam int BIT_CENT_EN = 7;
  localparam int BIT_CENT = 6;
  localparam int BIT_OUT = 7;
  localparam int BIT_PROBE = 6;
  localparam int BIT_DIR = 5;
  localparam logic [7:0] MASK_SEC = 8'h7F;
  localparam logic [7:0] MASK_MIN = 8'h7F;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_DOW = 8'h07;
  localparam logic [7:0] MASK_DATE = 8'h3F;
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MASK_YEAR = 8'hFF;
  localparam logic [7:0] MASK_MAG = 8'h1F;

  // ==========================================================
  // Timing
  localparam int OSC_HZ = 32768;
  localparam int PROBE_HZ = 512;
  localparam int PROBE_BIT = $clog2(OSC_HZ / PROBE_HZ) - 1;
  localparam int SHORT_CYC = 128;
  localparam int LONG_CYC = 256;
  localparam logic [15:0] TERM_NORM = 16'(OSC_HZ - 1);
  localparam logic [15:0] TERM_FAST = 16'(OSC_HZ - 1 - SHORT_CYC);
  localparam logic [15:0] TERM_SLOW = 16'(OSC_HZ - 1 + LONG_CYC);

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] dow;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic cb;
  } bcc_time_t;

  typedef struct packed {
    logic osc_halt;
    logic osc_fault_flag;
    logic century_toggle_enable;
    logic freq_probe_enable;
    logic out_level;
    logic trim_dir;
    logic [4:0] trim_mag;
  } bcc_ctrl_t;

  typedef struct packed {
    bcc_time_t t_int;
    bcc_time_t t_usr;
    bcc_ctrl_t ctrl;
    logic [15:0] div;
    logic [5:0] raw;
    logic [5:0] cal_min;
    logic [2:0] ptr;
    logic freeze;
    logic [7:0] rd_data;
    logic pin_oe;
    logic pin_o;
  } bcc_state_t;

  // ==========================================================
  // Reset values
  localparam bcc_time_t TIME_RST = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 1'b0};
  localparam bcc_ctrl_t CTRL_RST = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 5'h00};

endpackage

// file: hw/bcc_time_step.sv
`timescale 1ns/10ps
`default_nettype none
module bcc_time_step
  import bcc_pkg::*;
(
  input wire bcc_time_t now_t,
  input wire logic cent_en,
  output var bcc_time_t next_t,
  output logic min_roll
);

  // ==========================================================
  // BCD helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic leap(input logic [7:0] y);
    if (!y[4]) begin
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
  endfunction

  function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02: return leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // ==========================================================
  // Cascade of BCD rollovers
  always_comb begin
    next_t = now_t;
    min_roll = 1'b0;
    if (now_t.sec == 8'h59) begin
      next_t.sec = 8'h00;
      min_roll = 1'b1;
      if (now_t.min == 8'h59) begin
        next_t.min = 8'h00;
        if (now_t.hour == 8'h23) begin
          next_t.hour = 8'h00;
          next_t.dow = (now_t.dow == 8'h07) ? 8'h01 : bcd_inc(now_t.dow);
          if (now_t.date == last_date(now_t.month, now_t.year)) begin
            next_t.date = 8'h01;
            if (now_t.month == 8'h12) begin
              next_t.month = 8'h01;
              if (now_t.year == 8'h99) begin
                next_t.year = 8'h00;
                next_t.cb = cent_en ? ~now_t.cb : now_t.cb;
              end else begin
                next_t.year = bcd_inc(now_t.year);
              end
            end else begin
              next_t.month = bcd_inc(now_t.month);
            end
          end else begin
            next_t.date = bcd_inc(now_t.date);
          end
        end else begin
          next_t.hour = bcd_inc(now_t.hour);
        end
      end else begin
        next_t.min = bcd_inc(now_t.min);
      end
    end else begin
      next_t.sec = bcd_inc(now_t.sec);
    end
  end

endmodule // bcc_time_step
`default_nettype wire

// file: bench/bcc_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module bcc_bus_model (
  input wire logic core_clk,
  output logic ptr_load,
  output logic [2:0] ptr_val,
  output logic wr,
  output logic [7:0] wr_data,
  output logic ack_clk,
  output logic rd_lvl,
  output logic stop
);
  // ==========================================================
  // Idle bus
  initial begin
    {ptr_load, ptr_val, wr, wr_data, ack_clk, rd_lvl, stop} = '0;
  end

  // ==========================================================
  // One strobe cycle per call, changed only at falling edges
  task automatic xfer(input logic ld, input logic [2:0] a, input logic w,
                      input logic [7:0] d, input logic ak);
    @(negedge core_clk);
    ptr_load = ld;
    ptr_val = a;
    wr = w;
    wr_data = d;
    ack_clk = ak;
    @(negedge core_clk);
    ptr_load = 1'b0;
    wr = 1'b0;
    ack_clk = 1'b0;
    // Released lines must not keep the last value
    ptr_val = ~a;
    wr_data = ~d;
  endtask

  // Dropping a read always ends with a stop pulse
  task automatic set_read(input logic v);
    @(negedge core_clk);
    rd_lvl = v;
    stop = !v;
    @(negedge core_clk);
    stop = 1'b0;
  endtask
endmodule // bcc_bus_model
`default_nettype wire

// file: bench/bcd_calendar_clock_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bcd_calendar_clock_core_tb;
  import bcc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic osc_fail_event = 1'b0;
  logic power_down = 1'b0;
  logic clk_en = 1'b1;
  logic ptr_load, wr, ack_clk, rd_lvl, stop, pin_o, pin_oe;
  logic [2:0] ptr_val, ptr;
  logic [7:0] wr_data, rd_data;
  int fails = 0;
  int compares = 0;

  // ==========================================================
  // Clock, partner and design
  always #50 core_clk = ~core_clk;

  bcc_bus_model m (.core_clk(core_clk), .ptr_load(ptr_load), .ptr_val(ptr_val), .wr(wr),
    .wr_data(wr_data), .ack_clk(ack_clk), .rd_lvl(rd_lvl), .stop(stop));

  // Oscillator ticks every cycle so one second is 32768 cycles
  bcc_core uut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .osc_tick(1'b1),
    .osc_fail_event(osc_fail_event), .power_down(power_down), .bus_ptr_load(ptr_load),
    .bus_ptr_val(ptr_val), .bus_wr(wr), .bus_wr_data(wr_data), .bus_ack_clk(ack_clk),
    .bus_read(rd_lvl), .bus_stop(stop), .rd_data(rd_data), .ptr(ptr),
    .freq_or_level_pin_o(pin_o), .freq_or_level_pin_oe(pin_oe));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    m.xfer(1'b1, a, 1'b0, 8'h00, 1'b0);
    chk("rd_data", exp, rd_data);
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    m.xfer(1'b1, a, 1'b0, 8'h00, 1'b0);
    m.xfer(1'b0, 3'h0, 1'b1, d, 1'b0);
  endtask

  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(ADDR_SEC, 8'h00);
    rd(ADDR_MIN, 8'h80);
    rd(ADDR_TRIM, 8'h80);
    chk("pin_oe", 8'h00, {7'h00, pin_oe});
    $display("test reset done");
  endtask

  task automatic t_regs();
    wr_reg(ADDR_DOW, 8'hFF);
    chk("rd_data", 8'h07, rd_data);
    m.xfer(1'b0, 3'h0, 1'b0, 8'h00, 1'b1);
    chk("ptr", 8'h04, {5'h00, ptr});
    m.xfer(1'b1, ADDR_TRIM, 1'b0, 8'h00, 1'b0);
    m.xfer(1'b0, 3'h0, 1'b0, 8'h00, 1'b1);
    chk("ptr", 8'h00, {5'h00, ptr});
    // Enable low must freeze the pointer too
    clk_en = 1'b0;
    m.xfer(1'b0, 3'h0, 1'b0, 8'h00, 1'b1);
    chk("ptr_frozen", 8'h00, {5'h00, ptr});
    clk_en = 1'b1;
    $display("test regs done");
  endtask

  task automatic t_roll();
    logic [7:0] tv[7];
    logic [7:0] ev[7];
    tv = '{8'h59, 8'h59, 8'hA3, 8'h07, 8'h31, 8'h12, 8'h99};
    ev = '{8'h00, 8'h00, 8'hC0, 8'h01, 8'h01, 8'h01, 8'h00};
    wr_reg(ADDR_TRIM, 8'h80);
    for (int i = 6; i >= 0; i--) begin
      wr_reg(3'(i), tv[i]);
    end
    // Seconds written last, so the divider restarts here
    repeat (32750) @(negedge core_clk);
    rd(ADDR_SEC, 8'h59);
    repeat (20) @(negedge core_clk);
    for (int i = 0; i < 7; i++) begin
      rd(3'(i), ev[i]);
    end
    $display("test rollover done");
  endtask

  task automatic t_freeze();
    rd(ADDR_SEC, 8'h00);
    m.set_read(1'b1);
    repeat (33000) @(negedge core_clk);
    chk("rd_data", 8'h00, rd_data);
    m.set_read(1'b0);
    @(negedge core_clk);
    chk("rd_data", 8'h01, rd_data);
    $display("test freeze done");
  endtask

  task automatic t_pin();
    logic p;
    int n;
    n = 0;
    wr_reg(ADDR_TRIM, 8'h00);
    chk("pin_oe", 8'h01, {7'h00, pin_oe});
    wr_reg(ADDR_TRIM, 8'h7F);
    p = pin_oe;
    repeat (256) begin
      @(negedge core_clk);
      if (pin_oe !== p) n++;
      p = pin_oe;
    end
    chk("pin_toggles", 8'h08, 8'(n));
    wr_reg(ADDR_SEC, 8'h80);
    repeat (2) @(negedge core_clk);
    chk("pin_oe", 8'h00, {7'h00, pin_oe});
    rd(ADDR_MIN, 8'h80);
    wr_reg(ADDR_SEC, 8'h00);
    wr_reg(ADDR_MIN, 8'h00);
    rd(ADDR_MIN, 8'h00);
    power_down = 1'b1;
    @(negedge core_clk);
    power_down = 1'b0;
    rd(ADDR_TRIM, 8'h3F);
    osc_fail_event = 1'b1;
    @(negedge core_clk);
    osc_fail_event = 1'b0;
    rd(ADDR_MIN, 8'h80);
    $display("test pin and flags done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_roll();
    t_freeze();
    t_pin();
    end_of_test();
  end

  // About 66k cycles expected; 90k means a hang
  initial begin
    #9000000;
    fails++;
    end_of_test();
  end
endmodule // bcd_calendar_clock_core_tb
`default_nettype wire
